// ==== pkg/cif_pkg.sv ====
package cif_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h01C;
  localparam logic [11:0] OFF_XFER_STATUS = 12'h020;
  localparam logic [11:0] OFF_IRQ_CLEAR   = 12'h024;
  localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h028;

  // interrupt flag bit positions
  localparam int unsigned BIT_TIMER_C  = 5;
  localparam int unsigned BIT_TIMER_B  = 4;
  localparam int unsigned BIT_TIMER_A  = 3;
  localparam int unsigned BIT_XFER_ERR = 2;

  // transfer status error bit positions
  localparam int unsigned BIT_RX_BREAK  = 6;
  localparam int unsigned BIT_RX_FRAME  = 5;
  localparam int unsigned BIT_RX_PARITY = 4;
  localparam int unsigned BIT_RX_OVF    = 0;
  localparam int unsigned BIT_TX_OVF    = 8;
  localparam int unsigned BIT_RX_RETRY  = 22;
  localparam int unsigned BIT_TX_RETRY  = 30;

  // timer event lanes
  localparam int unsigned TIMER_A = 0;
  localparam int unsigned TIMER_B = 1;
  localparam int unsigned TIMER_C = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              pwrite;
    logic              psel;
    logic              penable;
    logic [DATA_W-1:0] pwdata;
  } cif_apb_req_s;

  typedef struct packed {
    logic rxBreakError;
    logic rxFrameError;
    logic rxParityError;
    logic rxBufferOverflow;
    logic txBufferOverflow;
    logic rxRetryLimitError;
    logic txRetryLimitError;
  } cif_err_s;

  typedef struct packed {
    logic timerCIrqFlag;
    logic timerBIrqFlag;
    logic timerAIrqFlag;
    logic transferErrorIrqFlag;
  } cif_flags_s;

  typedef struct packed {
    cif_flags_s        irqFlags;
    cif_flags_s        irqEnable;
    cif_err_s          transferStatus;
    logic [DATA_W-1:0] prdata;
  } cif_state_s;

  localparam cif_flags_s        FLAGS_RST = '0;
  localparam cif_err_s          ERR_RST   = '0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // flag set to bus word
  function automatic logic [DATA_W-1:0] cif_flags_word(input cif_flags_s f);
    logic [DATA_W-1:0] w;
    w = WORD_ZERO;
    w[BIT_TIMER_C]  = f.timerCIrqFlag;
    w[BIT_TIMER_B]  = f.timerBIrqFlag;
    w[BIT_TIMER_A]  = f.timerAIrqFlag;
    w[BIT_XFER_ERR] = f.transferErrorIrqFlag;
    return w;
  endfunction

  // bus word to flag set
  function automatic cif_flags_s cif_word_flags(input logic [DATA_W-1:0] w);
    cif_flags_s f;
    f.timerCIrqFlag        = w[BIT_TIMER_C];
    f.timerBIrqFlag        = w[BIT_TIMER_B];
    f.timerAIrqFlag        = w[BIT_TIMER_A];
    f.transferErrorIrqFlag = w[BIT_XFER_ERR];
    return f;
  endfunction

  // error set to bus word
  function automatic logic [DATA_W-1:0] cif_err_word(input cif_err_s e);
    logic [DATA_W-1:0] w;
    w = WORD_ZERO;
    w[BIT_RX_BREAK]  = e.rxBreakError;
    w[BIT_RX_FRAME]  = e.rxFrameError;
    w[BIT_RX_PARITY] = e.rxParityError;
    w[BIT_RX_OVF]    = e.rxBufferOverflow;
    w[BIT_TX_OVF]    = e.txBufferOverflow;
    w[BIT_RX_RETRY]  = e.rxRetryLimitError;
    w[BIT_TX_RETRY]  = e.txRetryLimitError;
    return w;
  endfunction

  // bus word to error set
  function automatic cif_err_s cif_word_err(input logic [DATA_W-1:0] w);
    cif_err_s e;
    e.rxBreakError      = w[BIT_RX_BREAK];
    e.rxFrameError      = w[BIT_RX_FRAME];
    e.rxParityError     = w[BIT_RX_PARITY];
    e.rxBufferOverflow  = w[BIT_RX_OVF];
    e.txBufferOverflow  = w[BIT_TX_OVF];
    e.rxRetryLimitError = w[BIT_RX_RETRY];
    e.txRetryLimitError = w[BIT_TX_RETRY];
    return e;
  endfunction

  // decoded register offsets
  function automatic logic cif_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_IRQ_STATUS) || (a == OFF_XFER_STATUS) ||
           (a == OFF_IRQ_CLEAR) || (a == OFF_IRQ_ENABLE);
  endfunction

endpackage

// ==== hdl/cif_irq_flags.sv ====
`timescale 1ns/1ps
module cif_irq_flags
  import cif_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire cif_apb_req_s      apbReq,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [2:0]        timerEvent,
  input  wire cif_err_s          errEvent,
  output cif_flags_s             irqFlags,
  output logic                   irq
);

  cif_state_s        s;
  cif_state_s        next_s;
  logic              setupRd;
  logic              accessWr;
  logic              mapped;
  cif_flags_s        clrFlags;
  cif_flags_s        setFlags;
  cif_err_s          clrErr;
  logic [DATA_W-1:0] rdWord;

  // bus phase decode
  assign setupRd  = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
  assign accessWr = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign mapped   = cif_mapped(apbReq.paddr);

  // zero wait states, error on unmapped access
  assign pready  = 1'b1;
  assign pslverr = apbReq.psel & apbReq.penable & ~mapped;

  // write strobes into clear masks
  always_comb begin
    clrFlags = FLAGS_RST;
    clrErr   = ERR_RST;
    if (accessWr) begin
      case (apbReq.paddr)
        OFF_IRQ_STATUS:  clrFlags = cif_word_flags(apbReq.pwdata);
        OFF_IRQ_CLEAR:   clrFlags = cif_word_flags(apbReq.pwdata);
        OFF_XFER_STATUS: clrErr   = cif_word_err(apbReq.pwdata);
        default:         clrFlags = FLAGS_RST;
      endcase
    end
  end

  // event sources into set masks
  always_comb begin
    setFlags.timerCIrqFlag        = timerEvent[TIMER_C];
    setFlags.timerBIrqFlag        = timerEvent[TIMER_B];
    setFlags.timerAIrqFlag        = timerEvent[TIMER_A];
    setFlags.transferErrorIrqFlag = errEvent.rxBreakError
      | errEvent.rxFrameError | errEvent.rxParityError
      | errEvent.rxBufferOverflow | errEvent.txBufferOverflow
      | errEvent.rxRetryLimitError | errEvent.txRetryLimitError;
  end

  // read multiplexer
  always_comb begin
    case (apbReq.paddr)
      OFF_IRQ_STATUS:  rdWord = cif_flags_word(s.irqFlags);
      OFF_XFER_STATUS: rdWord = cif_err_word(s.transferStatus);
      OFF_IRQ_ENABLE:  rdWord = cif_flags_word(s.irqEnable);
      default:         rdWord = WORD_ZERO; // clear register is write-only
    endcase
  end

  // next state
  always_comb begin
    next_s = s;
    // set ORed after clear so a coinciding event survives
    next_s.irqFlags = cif_flags_s'((s.irqFlags & ~clrFlags) | setFlags);
    next_s.transferStatus = cif_err_s'((s.transferStatus & ~clrErr) | errEvent);
    if (accessWr && apbReq.paddr == OFF_IRQ_ENABLE) begin
      next_s.irqEnable = cif_word_flags(apbReq.pwdata);
    end
    if (setupRd) begin
      next_s.prdata = rdWord;
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s.irqFlags       <= FLAGS_RST;
      s.irqEnable      <= FLAGS_RST;
      s.transferStatus <= ERR_RST;
      s.prdata         <= WORD_ZERO;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign prdata   = s.prdata;
  assign irqFlags = s.irqFlags;
  assign irq      = |(s.irqFlags & s.irqEnable);

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic statusWr;
  logic clearWr;
  assign statusWr = accessWr && (apbReq.paddr == OFF_IRQ_STATUS);
  assign clearWr  = accessWr &&
                    (apbReq.paddr == OFF_IRQ_STATUS || apbReq.paddr == OFF_IRQ_CLEAR);

  a_timer_c_set: assert property (
    timerEvent[TIMER_C] |=> s.irqFlags.timerCIrqFlag && (irq || !s.irqEnable.timerCIrqFlag))
    else $error("third timer flag not set");

  a_timer_c_quiet: assert property (
    !timerEvent[TIMER_C] && !s.irqFlags.timerCIrqFlag |=> !s.irqFlags.timerCIrqFlag)
    else $error("third timer flag rose without event");

  a_timer_b_set: assert property (
    timerEvent[TIMER_B] |=> s.irqFlags.timerBIrqFlag)
    else $error("second timer flag not set");

  a_timer_a_set: assert property (
    timerEvent[TIMER_A] && !timerEvent[TIMER_B] |=> s.irqFlags.timerAIrqFlag
      && (s.irqFlags.timerBIrqFlag == $past(s.irqFlags.timerBIrqFlag) || $past(accessWr)))
    else $error("first timer flag not set");

  a_clear_one: assert property (
    statusWr && apbReq.pwdata[BIT_TIMER_C] && !timerEvent[TIMER_C]
      |=> !s.irqFlags.timerCIrqFlag)
    else $error("write one did not clear flag");

  a_write_zero: assert property (
    statusWr && !apbReq.pwdata[BIT_XFER_ERR] && s.irqFlags.transferErrorIrqFlag
      |=> s.irqFlags.transferErrorIrqFlag)
    else $error("write zero cleared flag");

  a_break_err: assert property (
    errEvent.rxBreakError |=> s.irqFlags.transferErrorIrqFlag
      && s.transferStatus.rxBreakError)
    else $error("break error missed");

  a_frame_parity: assert property (
    errEvent.rxFrameError || errEvent.rxParityError |=> s.irqFlags.transferErrorIrqFlag)
    else $error("frame or parity error missed");

  a_overflow_err: assert property (
    errEvent.rxBufferOverflow || errEvent.txBufferOverflow
      |=> s.irqFlags.transferErrorIrqFlag)
    else $error("overflow error missed");

  a_retry_err: assert property (
    errEvent.rxRetryLimitError || errEvent.txRetryLimitError
      |=> s.irqFlags.transferErrorIrqFlag)
    else $error("retry limit error missed");

  a_set_wins: assert property (
    clearWr && apbReq.pwdata[BIT_TIMER_B] && timerEvent[TIMER_B]
      |=> s.irqFlags.timerBIrqFlag)
    else $error("clear beat coinciding set");

  a_read_data: assert property (
    setupRd && apbReq.paddr == OFF_IRQ_STATUS
      |=> prdata == cif_flags_word($past(s.irqFlags)))
    else $error("status read data wrong");

  // helper decodes for the checks below
  logic enableWr;
  logic xferWr;
  logic anyErr;
  assign enableWr = accessWr && (apbReq.paddr == OFF_IRQ_ENABLE);
  assign xferWr   = accessWr && (apbReq.paddr == OFF_XFER_STATUS);
  assign anyErr   = |errEvent;

  // flags stay low with no event
  a_timer_b_quiet: assert property (
    !timerEvent[TIMER_B] && !s.irqFlags.timerBIrqFlag |=> !s.irqFlags.timerBIrqFlag)
    else $error("second timer flag rose without event");

  a_timer_a_quiet: assert property (
    !timerEvent[TIMER_A] && !s.irqFlags.timerAIrqFlag |=> !s.irqFlags.timerAIrqFlag)
    else $error("first timer flag rose without event");

  a_xfer_quiet: assert property (
    !anyErr && !s.irqFlags.transferErrorIrqFlag |=> !s.irqFlags.transferErrorIrqFlag)
    else $error("transfer error flag rose without event");

  // writing one to a flag clears it
  a_clear_timer_b: assert property (
    clearWr && apbReq.pwdata[BIT_TIMER_B] && !timerEvent[TIMER_B]
      |=> !s.irqFlags.timerBIrqFlag)
    else $error("write one did not clear second timer flag");

  a_clear_timer_a: assert property (
    clearWr && apbReq.pwdata[BIT_TIMER_A] && !timerEvent[TIMER_A]
      |=> !s.irqFlags.timerAIrqFlag)
    else $error("write one did not clear first timer flag");

  a_clear_xfer: assert property (
    clearWr && apbReq.pwdata[BIT_XFER_ERR] && !anyErr
      |=> !s.irqFlags.transferErrorIrqFlag)
    else $error("write one did not clear transfer error flag");

  // writing zero leaves a flag alone
  a_zero_timer_c: assert property (
    clearWr && !apbReq.pwdata[BIT_TIMER_C] && s.irqFlags.timerCIrqFlag
      |=> s.irqFlags.timerCIrqFlag)
    else $error("write zero cleared third timer flag");

  a_zero_timer_b: assert property (
    clearWr && !apbReq.pwdata[BIT_TIMER_B] && s.irqFlags.timerBIrqFlag
      |=> s.irqFlags.timerBIrqFlag)
    else $error("write zero cleared second timer flag");

  a_zero_timer_a: assert property (
    clearWr && !apbReq.pwdata[BIT_TIMER_A] && s.irqFlags.timerAIrqFlag
      |=> s.irqFlags.timerAIrqFlag)
    else $error("write zero cleared first timer flag");

  // flags only fall on a clear write
  a_hold_timer_c: assert property (
    s.irqFlags.timerCIrqFlag && !clearWr |=> s.irqFlags.timerCIrqFlag)
    else $error("third timer flag fell without clear");

  a_hold_xfer: assert property (
    s.irqFlags.transferErrorIrqFlag && !clearWr |=> s.irqFlags.transferErrorIrqFlag)
    else $error("transfer error flag fell without clear");

  a_xfer_keeps_flag: assert property (
    xferWr && s.irqFlags.transferErrorIrqFlag |=> s.irqFlags.transferErrorIrqFlag)
    else $error("status write cleared transfer error flag");

  // set beats a coinciding clear
  a_set_wins_c: assert property (
    clearWr && apbReq.pwdata[BIT_TIMER_C] && timerEvent[TIMER_C]
      |=> s.irqFlags.timerCIrqFlag)
    else $error("clear beat third timer set");

  a_set_wins_a: assert property (
    clearWr && apbReq.pwdata[BIT_TIMER_A] && timerEvent[TIMER_A]
      |=> s.irqFlags.timerAIrqFlag)
    else $error("clear beat first timer set");

  // error events land in the transfer status
  a_frame_status: assert property (
    errEvent.rxFrameError |=> s.transferStatus.rxFrameError)
    else $error("frame error status missed");

  a_parity_status: assert property (
    errEvent.rxParityError |=> s.transferStatus.rxParityError)
    else $error("parity error status missed");

  a_rx_ovf_status: assert property (
    errEvent.rxBufferOverflow |=> s.transferStatus.rxBufferOverflow)
    else $error("receive overflow status missed");

  a_tx_retry_status: assert property (
    errEvent.txRetryLimitError |=> s.transferStatus.txRetryLimitError)
    else $error("transmit retry status missed");

  // transfer status is sticky until written with ones
  a_status_hold: assert property (
    s.transferStatus.rxBreakError && !xferWr |=> s.transferStatus.rxBreakError)
    else $error("break status fell without clear");

  a_status_clear: assert property (
    xferWr && apbReq.pwdata[BIT_RX_BREAK] && !errEvent.rxBreakError
      |=> !s.transferStatus.rxBreakError)
    else $error("break status not cleared");

  // enable register and interrupt line
  a_enable_write: assert property (
    enableWr |=> s.irqEnable == cif_word_flags($past(apbReq.pwdata)))
    else $error("enable write lost");

  a_enable_hold: assert property (
    !enableWr |=> $stable(s.irqEnable))
    else $error("enable changed without write");

  a_irq_rise: assert property (
    timerEvent[TIMER_A] && s.irqEnable.timerAIrqFlag && !enableWr |=> irq)
    else $error("enabled event raised no interrupt");

  a_irq_masked: assert property (
    enableWr && (apbReq.pwdata & cif_flags_word('1)) == WORD_ZERO
      |=> !irq)
    else $error("interrupt high with all enables off");

  // register bus answers
  a_pready_high: assert property (
    apbReq.psel |-> pready)
    else $error("wait state inserted");

  a_prdata_hold: assert property (
    !setupRd |=> $stable(prdata))
    else $error("read data changed outside read setup");

  a_read_enable: assert property (
    setupRd && apbReq.paddr == OFF_IRQ_ENABLE
      |=> prdata == cif_flags_word($past(s.irqEnable)))
    else $error("enable read data wrong");

  a_read_xfer: assert property (
    setupRd && apbReq.paddr == OFF_XFER_STATUS
      |=> prdata == cif_err_word($past(s.transferStatus)))
    else $error("transfer status read data wrong");

  a_read_clear: assert property (
    setupRd && apbReq.paddr == OFF_IRQ_CLEAR |=> prdata == WORD_ZERO)
    else $error("clear register read not zero");

  a_read_unmapped: assert property (
    setupRd && !mapped |=> prdata == WORD_ZERO)
    else $error("unmapped read not zero");

  a_reserved_zero: assert property (
    setupRd && apbReq.paddr == OFF_IRQ_STATUS
      |=> (prdata & ~cif_flags_word('1)) == WORD_ZERO)
    else $error("reserved status bits not zero");

  a_unmapped_ignored: assert property (
    accessWr && !mapped && !(|timerEvent) && !anyErr
      |=> s.irqFlags == $past(s.irqFlags) && s.irqEnable == $past(s.irqEnable))
    else $error("unmapped write changed state");

  c_timer_irq: cover property (
    timerEvent[TIMER_C] && s.irqEnable.timerCIrqFlag ##1 irq);

  c_set_clear: cover property (
    clearWr && apbReq.pwdata[BIT_TIMER_C] && timerEvent[TIMER_C]);

  c_clear_flag: cover property (
    s.irqFlags.timerAIrqFlag ##1 statusWr ##1 !s.irqFlags.timerAIrqFlag);

  c_error_irq: cover property (
    anyErr && s.irqEnable.transferErrorIrqFlag ##1 irq);

  c_unmapped: cover property (
    apbReq.psel && apbReq.penable && pslverr);

endmodule

// ==== test/cif_irq_flags_bench.sv ====
`timescale 1ns/1ps
module cif_irq_flags_bench
  import cif_pkg::*;
  ;
  localparam logic [31:0] FLAG_MASK = 32'h0000_003C;
  localparam int unsigned ERR_POS [7] = '{BIT_TX_RETRY, BIT_RX_RETRY, BIT_TX_OVF, BIT_RX_OVF,
                                          BIT_RX_PARITY, BIT_RX_FRAME, BIT_RX_BREAK};
  localparam logic [11:0] ADDRS [5] = '{OFF_IRQ_STATUS, OFF_XFER_STATUS, OFF_IRQ_CLEAR,
                                        OFF_IRQ_ENABLE, 12'h030};
  logic              clk;
  logic              arst_n;
  cif_apb_req_s      apbReq;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [2:0]        timerEvent;
  cif_err_s          errEvent;
  cif_flags_s        irqFlags;
  logic              irq;
  logic [31:0]       expFlags;
  logic [31:0]       expStat;
  logic [31:0]       expEn;
  logic [38:0]       noteQ [$];
  logic [15:0]       lfsrState;
  int                n_errors;
  int                n_checks;
  int                cycles;

  cif_irq_flags DUT (
    .clk        (clk),
    .arst_n     (arst_n),
    .apbReq     (apbReq),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .timerEvent (timerEvent),
    .errEvent   (errEvent),
    .irqFlags   (irqFlags),
    .irq        (irq)
  );

  // clock source
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [38:0] seen, input logic [38:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // reference model of flag and status sets
  task automatic apply_ev(input logic [2:0] t, input logic [6:0] e);
    expFlags[BIT_TIMER_A] |= t[TIMER_A];
    expFlags[BIT_TIMER_B] |= t[TIMER_B];
    expFlags[BIT_TIMER_C] |= t[TIMER_C];
    if (e != 7'h00) expFlags[BIT_XFER_ERR] = 1'b1;
    for (int k = 0; k < 7; k++) if (e[k]) expStat[ERR_POS[k]] = 1'b1;
  endtask

  task automatic pulse(input logic [2:0] t, input logic [6:0] e);
    @(posedge clk);
    timerEvent <= t;
    errEvent   <= e;
    @(posedge clk);
    timerEvent <= 3'h0;
    errEvent   <= ERR_RST;
    apply_ev(t, e);
  endtask

  // one apb transfer, t pulses timer events during the access cycle
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [2:0] t);
    logic [31:0] rd;
    logic        bad;
    bad = !(a == OFF_IRQ_STATUS || a == OFF_XFER_STATUS || a == OFF_IRQ_CLEAR ||
            a == OFF_IRQ_ENABLE);
    rd = (a == OFF_IRQ_STATUS) ? expFlags : (a == OFF_XFER_STATUS) ? expStat :
         (a == OFF_IRQ_ENABLE) ? expEn : 32'h0000_0000;
    @(posedge clk);
    apbReq <= '{paddr: a, pwrite: w, psel: 1'b1, penable: 1'b0, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    timerEvent     <= t;
    noteQ.push_back({w, |(expFlags & expEn), bad, expFlags[5:2], rd});
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
    timerEvent     <= 3'h0;
    if (w && (a == OFF_IRQ_STATUS || a == OFF_IRQ_CLEAR)) expFlags &= ~d;
    if (w && a == OFF_XFER_STATUS) expStat &= ~d;
    if (w && a == OFF_IRQ_ENABLE) expEn = d & FLAG_MASK;
    apply_ev(t, 7'h00);
  endtask

  // monitor: compares each completed transfer with the oldest note
  always @(posedge clk) begin
    logic [38:0] note;
    if ((arst_n && apbReq.psel && apbReq.penable && pready) === 1'b1) begin
      if (noteQ.size() == 0) begin
        check(39'h0, 39'h1);
      end else begin
        note = noteQ.pop_front();
        check(39'(pslverr), 39'(note[36]));
        if (!note[38]) begin
          check(39'(prdata), 39'(note[31:0]));
          check(39'(irqFlags), 39'(note[35:32]));
          check(39'(irq), 39'(note[37]));
        end
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    apbReq = '0;
    timerEvent = 3'h0;
    errEvent = ERR_RST;
    arst_n = 1'b0;
    {expFlags, expStat, expEn} = '0;
    lfsrState = 16'h0034;
    {n_errors, n_checks, cycles} = '0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ADDRS[i]) apb(ADDRS[i], 1'b0, 32'h0000_0000, 3'h0);
    apb(OFF_IRQ_ENABLE, 1'b1, 32'hFFFF_FFFF, 3'h0);
    // timers: set, write zero, clear
    for (int i = 0; i < 3; i++) begin
      pulse(3'(3'h1 << i), 7'h00);
      apb(OFF_IRQ_STATUS, 1'b0, 32'h0000_0000, 3'h0);
      apb(OFF_IRQ_STATUS, 1'b1, 32'h0000_0000, 3'h0);
      apb(OFF_IRQ_STATUS, 1'b0, 32'h0000_0000, 3'h0);
      apb(i[0] ? OFF_IRQ_CLEAR : OFF_IRQ_STATUS, 1'b1, 32'h0000_0038, 3'h0);
      apb(OFF_IRQ_STATUS, 1'b0, 32'h0000_0000, 3'h0);
    end
    // each error source alone
    for (int k = 0; k < 7; k++) begin
      pulse(3'h0, 7'(7'h01 << k));
      apb(OFF_XFER_STATUS, 1'b0, 32'h0000_0000, 3'h0);
      apb(OFF_XFER_STATUS, 1'b1, 32'hFFFF_FFFF, 3'h0);
      apb(OFF_IRQ_STATUS, 1'b0, 32'h0000_0000, 3'h0);
      apb(OFF_IRQ_CLEAR, 1'b1, 32'h0000_0004, 3'h0);
      apb(OFF_IRQ_STATUS, 1'b0, 32'h0000_0000, 3'h0);
    end
    // set beats a coinciding clear, then masking and unmapped write
    apb(OFF_IRQ_CLEAR, 1'b1, FLAG_MASK, 3'h7);
    apb(OFF_IRQ_STATUS, 1'b0, 32'h0000_0000, 3'h0);
    apb(OFF_IRQ_ENABLE, 1'b1, 32'h0000_0000, 3'h0);
    apb(OFF_IRQ_STATUS, 1'b0, 32'h0000_0000, 3'h0);
    apb(12'h030, 1'b1, 32'hFFFF_FFFF, 3'h0);
    apb(OFF_IRQ_STATUS, 1'b0, 32'h0000_0000, 3'h0);
    // random traffic
    repeat (20) begin
      lfsrState = lfsr(lfsrState);
      pulse(lfsrState[2:0], lfsrState[9:3]);
      apb(OFF_IRQ_ENABLE, 1'b1, {16'h0000, lfsrState}, 3'h0);
      lfsrState = lfsr(lfsrState);
      apb(ADDRS[lfsrState[1:0]], 1'b1, {lfsrState, lfsrState}, lfsrState[4:2]);
      apb(OFF_IRQ_STATUS, 1'b0, 32'h0000_0000, 3'h0);
      apb(OFF_XFER_STATUS, 1'b0, 32'h0000_0000, 3'h0);
    end
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule
